// [verilog/rx_control_word_decoder.sv]
// Decoder for the second receive process-data message.
`include "rx_control_word_decoder_params.svh"
module rx_control_word_decoder #(
	parameter int CLAMP_DELAY = `CLAMP_DELAY_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic msg_valid,
	input wire logic [63:0] msg_bytes,
	input wire logic node_operational,
	input wire logic clamping_mode,
	input wire logic positioning_active,
	input wire logic moving,
	input wire logic end_stop_low,
	input wire logic end_stop_high,
	input wire logic invert_count_dir,
	input wire logic invert_motor_dir,
	input wire logic sdo_offset_write,
	input wire logic [31:0] sdo_offset_data,
	output logic [31:0] offset_reg,
	output logic [31:0] set_value_reg,
	output logic [31:0] slot_three_reg,
	output logic [15:0] echo_corr_reg,
	output rx_control_word_decoder_pkg::set_command_s set_cmd_reg,
	output logic set_cmd_pulse,
	output logic stop_pulse,
	output logic abort_pulse,
	output logic clamp_open_pulse,
	output logic clamp_close_pulse,
	output logic clamp_released,
	output logic motor_run,
	output logic motor_dir_up,
	output logic [1:0] jog_speed_reg,
	output logic emcy_pulse,
	output logic [15:0] emcy_code
);
	import rx_control_word_decoder_pkg::*;

	logic rst_meta;
	logic rst_sync_n;
	rx_message_s msg;
	logic permitted;
	logic is_zero;
	logic take;
	logic stop_req;
	logic exec;
	logic jog_req;
	logic clamp_req;
	logic set_req;
	logic corr_is_switch;
	logic jog_right_reg;
	logic jog_start;
	logic jog_stop;
	logic at_end;
	logic delay_done;
	logic [31:0] delay_cnt_reg;
	logic [31:0] delay_cnt_next;
	jog_state_e jog_reg;
	jog_state_e jog_next;

	// Reset is released through two flops so the design leaves it cleanly.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	message_unpacker unpack (
		.raw_bytes(msg_bytes),
		.message(msg)
	);

	control_word_checker check (
		.control(msg.control),
		.permitted(permitted),
		.is_zero(is_zero)
	);

	// Message qualification; bit 15 enters only the is_zero test below.
	// operational only
	assign take = msg_valid && node_operational && clk_en;
	assign stop_req = take && msg.control[`CW_STOP];
	assign exec = take && !msg.control[`CW_STOP] && !is_zero &&
		permitted && msg.control[`CW_ENABLE];
	assign jog_req = exec && (msg.control[`CW_RIGHT] ||
		msg.control[`CW_LEFT]);
	assign clamp_req = exec && msg.control[`CW_CLAMP];
	assign set_req = exec && !jog_req && !clamp_req;
	assign corr_is_switch = (msg.correction == `CORR_SWITCH);

	// Offset follows 16-bit corrections; the switch value hands it to SDO.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			offset_reg <= 32'h0000_0000;
		end else if (clk_en && set_req && !corr_is_switch) begin
			offset_reg <= {{16{msg.correction[15]}}, msg.correction};
		end else if (clk_en && sdo_offset_write) begin
			offset_reg <= sdo_offset_data;
		end
	end

	// Echo and set-value storage; jogs leave the stored values alone.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			echo_corr_reg <= 16'h0000;
			set_value_reg <= 32'h0000_0000;
			slot_three_reg <= 32'h0000_0000;
		end else if (set_req) begin
			echo_corr_reg <= msg.correction;
			if (msg.control[`CW_FUNC_LO]) begin
				slot_three_reg <= msg.set_value;
			end else begin
				set_value_reg <= msg.set_value;
			end
		end
	end

	// Set command fields for the positioning logic outside.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			set_cmd_reg <= '0;
			set_cmd_pulse <= 1'b0;
		end else if (clk_en) begin
			set_cmd_pulse <= set_req && !msg.control[`CW_FUNC_LO];
			if (set_req) begin
				set_cmd_reg.start_set <= msg.control[`CW_RELEASE];
				set_cmd_reg.load_set <= !msg.control[`CW_RELEASE];
				set_cmd_reg.speed <= msg.control[`CW_SPEED_HI:`CW_SPEED_LO];
				set_cmd_reg.cut_in <=
					(msg.control[`CW_SPEED_HI:`CW_SPEED_LO] != 2'h0);
				set_cmd_reg.no_comp <= msg.control[`CW_NO_COMP];
				set_cmd_reg.store_slot3 <= msg.control[`CW_FUNC_LO];
			end
		end
	end

	// Clamp and emergency events are one-cycle pulses.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			clamp_open_pulse <= 1'b0;
			clamp_close_pulse <= 1'b0;
			emcy_pulse <= 1'b0;
			stop_pulse <= 1'b0;
			abort_pulse <= 1'b0;
		end else if (clk_en) begin
			clamp_open_pulse <= clamp_req && clamping_mode && !moving &&
				!msg.control[`CW_RELEASE];
			clamp_close_pulse <= clamp_req && clamping_mode && !moving &&
				msg.control[`CW_RELEASE];
			// emergency on bad
			// A word without enable and without stop is dropped quietly.
			emcy_pulse <= take && !is_zero && !permitted &&
				msg.control[`CW_ENABLE];
			stop_pulse <= stop_req;
			abort_pulse <= jog_start && positioning_active;
		end
	end

	assign emcy_code = `EMCY_BAD_COMBO;

	// Jog sequencing; a new jog is refused while one is already running.
	assign jog_start = jog_req && (jog_reg == JOG_IDLE);
	assign at_end = jog_right_reg ? end_stop_high : end_stop_low;
	assign jog_stop = stop_req || at_end;
	assign delay_done = (delay_cnt_reg == 32'h0000_0000);

	always_comb begin
		jog_next = jog_reg;
		delay_cnt_next = delay_done ? 32'h0000_0000 :
			delay_cnt_reg - 32'h0000_0001;
		case (jog_reg)
			JOG_IDLE: begin
				if (jog_start && clamping_mode) begin
					jog_next = JOG_RELEASE;
					delay_cnt_next = CLAMP_DELAY[31:0];
				end else if (jog_start) begin
					jog_next = JOG_RUN;
				end
			end
			JOG_RELEASE: begin
				if (stop_req) begin
					jog_next = JOG_ENGAGE;
					delay_cnt_next = CLAMP_DELAY[31:0];
				end else if (delay_done) begin
					jog_next = JOG_RUN;
				end
			end
			JOG_RUN: begin
				if (jog_stop && clamping_mode) begin
					jog_next = JOG_ENGAGE;
					delay_cnt_next = CLAMP_DELAY[31:0];
				end else if (jog_stop) begin
					jog_next = JOG_IDLE;
				end
			end
			JOG_ENGAGE: begin
				if (delay_done) begin
					jog_next = JOG_IDLE;
				end
			end
			default: begin
				jog_next = JOG_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			jog_reg <= JOG_IDLE;
			delay_cnt_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			jog_reg <= jog_next;
			delay_cnt_reg <= delay_cnt_next;
		end
	end

	// Jog direction and speed are latched when the jog is started.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			jog_right_reg <= 1'b0;
			jog_speed_reg <= 2'h0;
		end else if (clk_en && jog_start) begin
			jog_right_reg <= msg.control[`CW_RIGHT];
			jog_speed_reg <= msg.control[`CW_SPEED_HI:`CW_SPEED_LO];
		end
	end

	// Direction is combinational so a changed inversion takes effect at once.
	// live inversion
	assign motor_dir_up = jog_right_reg ^ invert_count_dir ^
		invert_motor_dir;
	assign motor_run = (jog_reg == JOG_RUN);
	assign clamp_released = (jog_reg == JOG_RELEASE) ||
		(jog_reg == JOG_RUN);
endmodule : rx_control_word_decoder

// [verilog/rx_control_word_decoder_params.svh]
// Constants for the receive control word decoder.
// Behaviour
// - Message holds signed set value, 16-bit correction, control word, in order.
// - A normal correction overwrites the 32-bit offset, sign-extended.
// - Correction -32768 leaves the stored offset untouched and uses it.
// - A later correction above -32768 writes the offset again.
// - Last received correction is echoed unchanged for transmit; the code echoes only the correction of a set-value command.
// - Commands execute only when enable bit 0 is one.
// - Motor stop executes even when enable is zero.
// - Bit 1 starts the motor for set-value commands, else load only.
// - With bit 9 set, bit 1 opens (0) or closes (1) clamp.
// - Bit 2 suppresses spindle compensation.
// - Bits 4:3 choose slow, medium or fast speed.
// - Bits 6:5 function: 01b stores set value to slot three.
// - Bit 7 jogs right counting up, bit 8 jogs left down.
// - Bit 14 stops the motor, ignoring everything else.
// - Bit 15 is ignored.
// - One jog message keeps moving until a stop arrives.
// - Jog stops automatically at either end stop.
// - Clamping mode wraps jog with delayed release and delayed engage.
// - Direction inversion changes act at once on a running jog.
// - Jog leaves stored offset and set value unchanged.
// - Starting a jog aborts active positioning.
// - Clamp command ignored silently if clamping off or moving.
// - Bad bit combinations raise emergency code 0x8230 instead.
// - All-zero control word is ignored silently.
// - Commands act only in the operational network state.
`ifndef RX_CONTROL_WORD_DECODER_PARAMS_SVH
`define RX_CONTROL_WORD_DECODER_PARAMS_SVH
`define CW_ENABLE 0
`define CW_RELEASE 1
`define CW_NO_COMP 2
`define CW_SPEED_LO 3
`define CW_SPEED_HI 4
`define CW_FUNC_LO 5
`define CW_FUNC_HI 6
`define CW_RIGHT 7
`define CW_LEFT 8
`define CW_CLAMP 9
`define CW_STOP 14
`define CORR_SWITCH 16'h8000
`define EMCY_BAD_COMBO 16'h8230
`define CLAMP_DELAY_MS 10
`define CLK_KHZ 200000
`define CLAMP_DELAY_CYC (`CLAMP_DELAY_MS * `CLK_KHZ)
`endif

// [verilog/rx_control_word_decoder_pkg.sv]
// Types shared by the receive control word decoder.
package rx_control_word_decoder_pkg;
	typedef struct packed {
		logic [15:0] control;
		logic [15:0] correction;
		logic [31:0] set_value;
	} rx_message_s;

	typedef struct packed {
		logic start_set;
		logic load_set;
		logic cut_in;
		logic no_comp;
		logic store_slot3;
		logic [1:0] speed;
	} set_command_s;

	typedef enum logic [3:0] {
		JOG_IDLE = 4'h1,
		JOG_RELEASE = 4'h2,
		JOG_RUN = 4'h4,
		JOG_ENGAGE = 4'h8
	} jog_state_e;
endpackage : rx_control_word_decoder_pkg

// [verilog/message_unpacker.sv]
// Unpacks an eight-byte receive message into its three fields.
module message_unpacker (
	input wire logic [63:0] raw_bytes,
	output rx_control_word_decoder_pkg::rx_message_s message
);
	import rx_control_word_decoder_pkg::*;

	assign message.set_value = {raw_bytes[31:24], raw_bytes[23:16],
		raw_bytes[15:8], raw_bytes[7:0]};
	assign message.correction = {raw_bytes[47:40], raw_bytes[39:32]};
	assign message.control = {raw_bytes[63:56], raw_bytes[55:48]};
endmodule : message_unpacker

// [verilog/control_word_checker.sv]
// Classifies a control word as permissible or not.
`include "rx_control_word_decoder_params.svh"
module control_word_checker (
	input wire logic [15:0] control,
	output logic permitted,
	output logic is_zero
);
	import rx_control_word_decoder_pkg::*;

	logic [1:0] func;
	logic [1:0] speed;
	logic low2;
	logic set_ok;
	logic jog_ok;
	logic clamp_ok;

	// Only combinations of the function table pass; reserved 13..10 are free.
	assign func = control[`CW_FUNC_HI:`CW_FUNC_LO];
	assign speed = control[`CW_SPEED_HI:`CW_SPEED_LO];
	assign low2 = control[`CW_NO_COMP];
	assign is_zero = (control == 16'h0000);
	assign set_ok = !control[`CW_CLAMP] && !control[`CW_LEFT] &&
		!control[`CW_RIGHT] && ((func != 2'h0) ||
		(low2 && control[`CW_RELEASE]) || !low2);
	assign jog_ok = !control[`CW_CLAMP] && (func == 2'h0) && !low2 &&
		!control[`CW_RELEASE] && (speed != 2'h0) &&
		(control[`CW_LEFT] != control[`CW_RIGHT]);
	assign clamp_ok = control[`CW_CLAMP] && !control[`CW_LEFT] &&
		!control[`CW_RIGHT] && (func == 2'h0) && (speed == 2'h0) &&
		!low2;
	assign permitted = control[`CW_STOP] || (control[`CW_ENABLE] &&
		(set_ok || jog_ok || clamp_ok) && (func != 2'h2) &&
		(func != 2'h3));
endmodule : control_word_checker

// [tb/fieldbus_master.sv]
// Behavioural fieldbus master that sends receive control messages.
module fieldbus_master (
	input wire logic core_clk,
	output logic msg_valid,
	output logic [63:0] msg_bytes
);
	timeunit 1ns;
	timeprecision 100ps;
	// The message line is idle until the first send.
	initial begin
		msg_valid = 1'b0;
		msg_bytes = 64'h0;
	end
	task automatic send(input logic [31:0] sv, input logic [15:0] cr,
		input logic [15:0] cw);
		@(posedge core_clk);
		#1;
		msg_valid = 1'b1;
		msg_bytes = {cw, cr, sv};
		@(posedge core_clk);
		#1;
		msg_valid = 1'b0;
		msg_bytes = ~msg_bytes; // Stale data must not look valid.
	endtask : send
endmodule : fieldbus_master

// [tb/rx_control_word_decoder_sva.sv]
// Port checks for the receive control word decoder.
module rx_control_word_decoder_sva (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic msg_valid,
	input wire logic [63:0] msg_bytes,
	input wire logic node_operational,
	input wire logic clamping_mode,
	input wire logic positioning_active,
	input wire logic end_stop_low,
	input wire logic invert_count_dir,
	input wire logic invert_motor_dir,
	input wire logic [31:0] offset_reg,
	input wire logic [31:0] set_value_reg,
	input wire logic [15:0] echo_corr_reg,
	input wire logic set_cmd_pulse,
	input wire logic stop_pulse,
	input wire logic abort_pulse,
	input wire logic motor_run,
	input wire logic motor_dir_up,
	input wire logic emcy_pulse,
	input wire logic [15:0] emcy_code
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [15:0] corr_reg;
	// Decoded view of the message being taken.
	wire take = msg_valid && node_operational && clk_en;
	wire [15:0] cw = msg_bytes[63:48];
	wire [15:0] cr = msg_bytes[47:32];
	wire set_type = take && cw[14:2] == 13'h0 && cw[0];
	wire jog = take && !cw[14] && cw[0] && (cw[8] ^ cw[7]) && cw[4:3] != 0;
	// The correction is kept because the bus changes after the take.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) corr_reg <= 16'h0;
		else if (take) corr_reg <= cr;
	end
	sequence s_off_still;
		##1 $stable(offset_reg) ##1 $stable(offset_reg);
	endsequence
	a_offset_sign_ext: assert property (
		set_type && cr != 16'h8000 |->
		##[1:2] offset_reg == {{16{corr_reg[15]}}, corr_reg})
		else $error("offset not loaded from correction");
	a_switch_keeps: assert property (
		set_type && cr == 16'h8000 |-> s_off_still)
		else $error("switch value changed offset");
	a_echo_corr: assert property (
		set_type |-> ##[1:2] echo_corr_reg == corr_reg)
		else $error("correction echo wrong");
	a_disabled_quiet: assert property (
		take && !cw[0] && !cw[14] |-> ##1 (!set_cmd_pulse && !emcy_pulse)[*2])
		else $error("disabled word acted");
	a_stop_follows: assert property (
		take && cw[14] |-> ##[1:2] stop_pulse ##1 !motor_run)
		else $error("stop not executed");
	a_bad_combo: assert property (
		take && cw == 16'h0181 |-> ##[1:2] emcy_pulse && emcy_code == 16'h8230)
		else $error("bad combination not reported");
	a_jog_right_up: assert property (
		take && cw == 16'h0089 && !clamping_mode && !motor_run |-> ##[1:2]
		motor_run && motor_dir_up == !(invert_count_dir ^ invert_motor_dir))
		else $error("right jog wrong");
	a_jog_keeps: assert property (
		jog |-> ##1 ($stable(offset_reg) && $stable(set_value_reg))[*2])
		else $error("jog changed stored values");
	a_jog_aborts: assert property (
		jog && positioning_active && !motor_run && !clamping_mode |->
		##[1:2] abort_pulse)
		else $error("jog did not abort positioning");
	a_end_stop_low: assert property (
		motor_run && !motor_dir_up && end_stop_low && !invert_count_dir &&
		!invert_motor_dir |-> ##[1:3] !motor_run)
		else $error("left end stop ignored");
	a_idle_node: assert property (
		msg_valid && !node_operational |-> s_off_still)
		else $error("message taken while not operational");
endmodule : rx_control_word_decoder_sva

// [tb/rx_control_word_decoder_bench.sv]
// Self-checking bench for the receive control word decoder.
module rx_control_word_decoder_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, reset_n, node_operational, clamping_mode, moving;
	logic positioning_active, end_stop_low, invert_count_dir;
	logic invert_motor_dir, sdo_offset_write, msg_valid;
	logic set_cmd_pulse, stop_pulse, abort_pulse, clamp_open_pulse;
	logic clamp_close_pulse, clamp_released, motor_run, motor_dir_up;
	logic emcy_pulse, clk_en, end_stop_high;
	logic [31:0] sdo_offset_data, offset_reg, set_value_reg, slot_three_reg;
	logic [31:0] off;
	logic [15:0] echo_corr_reg, emcy_code, cw, cr, ec;
	logic [1:0] jog_speed_reg;
	logic [63:0] msg_bytes;
	logic [5:0] seen, fl;
	rx_control_word_decoder_pkg::set_command_s set_cmd_reg;
	int n_fail = 0;
	int compares = 0;
	// Control, correction, offset, echo, pulses {set,stop,abort,op,cl,emcy}.
	logic [85:0] rows [8] = '{
		{16'h0001, 16'h0005, 32'h00000005, 16'h0005, 6'h20},
		{16'h0007, 16'hFFFE, 32'hFFFFFFFE, 16'hFFFE, 6'h20},
		{16'h8001, 16'h8000, 32'hFFFFFFFE, 16'h8000, 6'h20},
		{16'h0019, 16'h7FFF, 32'h00007FFF, 16'h7FFF, 6'h20},
		{16'h0002, 16'h0003, 32'h00007FFF, 16'h7FFF, 6'h00},
		{16'h0000, 16'h0009, 32'h00007FFF, 16'h7FFF, 6'h00},
		{16'h0181, 16'h0009, 32'h00007FFF, 16'h7FFF, 6'h01},
		{16'h4000, 16'h0001, 32'h00007FFF, 16'h7FFF, 6'h10}};
	rx_control_word_decoder #(.CLAMP_DELAY(4)) rx_control_word_decoder_i (
		.core_clk, .reset_n, .clk_en, .msg_valid, .msg_bytes,
		.node_operational, .clamping_mode, .positioning_active, .moving,
		.end_stop_low, .end_stop_high, .invert_count_dir,
		.invert_motor_dir, .sdo_offset_write, .sdo_offset_data, .offset_reg,
		.set_value_reg, .slot_three_reg, .echo_corr_reg, .set_cmd_reg,
		.set_cmd_pulse, .stop_pulse, .abort_pulse, .clamp_open_pulse,
		.clamp_close_pulse, .clamp_released, .motor_run, .motor_dir_up,
		.jog_speed_reg, .emcy_pulse, .emcy_code);
	fieldbus_master fieldbus_master_i (.core_clk, .msg_valid, .msg_bytes);
	// Pulses are gathered so that their exact cycle does not matter.
	always @(posedge core_clk) begin
		seen <= seen | {set_cmd_pulse, stop_pulse, abort_pulse,
			clamp_open_pulse, clamp_close_pulse, emcy_pulse};
	end
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	// One message, then three cycles for every answer to settle.
	task automatic msg(input logic [31:0] sv, input logic [15:0] c,
		input logic [15:0] w);
		seen = 6'h0;
		fieldbus_master_i.send(sv, c, w);
		repeat (3) @(posedge core_clk);
		#1;
	endtask : msg
	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	// The run takes under two hundred cycles, so this leaves wide margin.
	initial begin
		#200000;
		n_fail++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		{node_operational, clamping_mode, positioning_active, moving} = 4'h8;
		{end_stop_low, invert_count_dir, invert_motor_dir} = 3'h0;
		{clk_en, end_stop_high} = 2'h2;
		sdo_offset_write = 1'b0;
		sdo_offset_data = 32'h0;
		seen = 6'h0;
		repeat (8) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check(offset_reg | set_value_reg | slot_three_reg, 32'h0);
		check(emcy_code, 16'h8230);
		for (int i = 0; i < 8; i++) begin
			{cw, cr, off, ec, fl} = rows[i];
			msg(32'h1234, cr, cw);
			check(offset_reg, off);
			check(echo_corr_reg, ec);
			check(seen, fl);
			if (fl[5]) check({set_cmd_reg.start_set, set_cmd_reg.no_comp,
				set_cmd_reg.speed}, {cw[1], cw[2], cw[4:3]});
			if (fl[5]) check({set_cmd_reg.load_set, set_cmd_reg.cut_in},
				{!cw[1], cw[4:3] != 2'h0});
			$display("row %0d done", i);
		end
		check(set_value_reg, 32'h1234);
		msg(32'h00ABCDEF, 16'h7FFF, 16'h0021);
		check(slot_three_reg, 32'h00ABCDEF);
		sdo_offset_write = 1'b1;
		sdo_offset_data = 32'h00012345;
		@(posedge core_clk);
		#1 sdo_offset_write = 1'b0;
		msg(32'h0, 16'h8000, 16'h0001);
		check(offset_reg, 32'h00012345);
		node_operational = 1'b0;
		msg(32'h0, 16'h0011, 16'h0001);
		check(offset_reg, 32'h00012345);
		node_operational = 1'b1;
		// A frozen block must not take a message either.
		clk_en = 1'b0;
		msg(32'h0, 16'h0042, 16'h0001);
		check(offset_reg, 32'h00012345);
		clk_en = 1'b1;
		$display("offset tests done");
		msg(32'h0, 16'h0005, 16'h0089);
		check({motor_run, motor_dir_up, jog_speed_reg}, 4'hD);
		check(offset_reg, 32'h00012345);
		repeat (20) @(posedge core_clk);
		#1 check(motor_run, 1'b1);
		msg(32'h0, 16'h0, 16'h4000);
		check(motor_run, 1'b0);
		positioning_active = 1'b1;
		msg(32'h0, 16'h0, 16'h0111);
		check({seen, motor_dir_up}, 7'h10);
		invert_motor_dir = 1'b1;
		@(posedge core_clk);
		#1 check(motor_dir_up, 1'b1);
		{invert_motor_dir, positioning_active, end_stop_low} = 3'h1;
		repeat (3) @(posedge core_clk);
		#1 check(motor_run, 1'b0);
		end_stop_low = 1'b0;
		msg(32'h0, 16'h0, 16'h0089);
		check(motor_run, 1'b1);
		end_stop_high = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 check(motor_run, 1'b0);
		end_stop_high = 1'b0;
		$display("jog tests done");
		clamping_mode = 1'b1;
		msg(32'h0, 16'h0, 16'h0203);
		check(seen, 6'h02);
		moving = 1'b1;
		msg(32'h0, 16'h0, 16'h0201);
		check(seen, 6'h00);
		moving = 1'b0;
		msg(32'h0, 16'h0, 16'h0201);
		check(seen, 6'h04);
		msg(32'h0, 16'h0, 16'h0089);
		check({clamp_released, motor_run}, 2'h2);
		repeat (8) @(posedge core_clk);
		#1 check(motor_run, 1'b1);
		msg(32'h0, 16'h0, 16'h4000);
		check(motor_run, 1'b0);
		$display("clamp tests done");
		final_report();
	end
endmodule : rx_control_word_decoder_bench
bind rx_control_word_decoder rx_control_word_decoder_sva
	rx_control_word_decoder_sva_i (.*);
